// ===== hw/lls_frame_watch.sv
`timescale 1ns/1ps
`default_nettype none
`include "lls_map.svh"
module lls_frame_watch #(
	parameter int LOST_FRAMES = `LLS_LOST_FRAMES
) (
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic frame_slot_in,
	input  wire logic frame_valid_in,
	output var  logic link_lost_out,
	output var  logic lost_event_out,
	output var  logic frame_seen_out
);
	logic [15:0] miss_cnt;
	logic        hit_limit;

	// last missing slot of the run reaches the limit
	assign hit_limit = frame_slot_in && !frame_valid_in &&
		(miss_cnt == 16'(LOST_FRAMES - 1));

	// a valid frame restarts the run of missing slots
	always_ff @(posedge clk_in) begin
		if (rst_in || frame_valid_in) begin
			miss_cnt <= 16'h0000;
		end else if (frame_slot_in && !link_lost_out) begin
			miss_cnt <= miss_cnt + 16'h0001;
		end
	end

	// flag: setting wins over clearing by a frame
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			link_lost_out <= 1'b0;
		end else if (hit_limit) begin
			link_lost_out <= 1'b1;
		end else if (frame_valid_in) begin
			link_lost_out <= 1'b0;
		end
	end

	// one pulse per loss; counter freezes while lost
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			lost_event_out <= 1'b0;
		end else begin
			lost_event_out <= hit_limit && !link_lost_out;
		end
	end

	// tells startup losses from losses in operation
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			frame_seen_out <= 1'b0;
		end else if (frame_valid_in) begin
			frame_seen_out <= 1'b1;
		end
	end

	a_lost_at_limit : assert property (@(posedge clk_in)
		disable iff (rst_in) hit_limit |=> link_lost_out)
		else $error("link lost flag not set at frame limit");

	a_frame_restart : assert property (@(posedge clk_in)
		disable iff (rst_in) frame_valid_in |=> miss_cnt == 16'h0000)
		else $error("valid frame did not restart the count");

	a_single_event : assert property (@(posedge clk_in)
		disable iff (rst_in) lost_event_out |-> !$past(link_lost_out))
		else $error("link loss acted on twice");

endmodule
`default_nettype wire

// ===== hw/lls_map.svh
`ifndef LLS_MAP_SVH
`define LLS_MAP_SVH
// ****************************************************************
// supervisor constants
// ****************************************************************
// missing frame slots before the link counts as lost
`define LLS_LOST_FRAMES 25000
// secure position value meaning "no secure positioning"
`define LLS_SEC_NONE 11'h400
// back-off after zeroing, in full steps
`define LLS_BACKOFF_FS 16'h000A
// half of the positioner range in full steps (plain default)
`define LLS_HALF_RANGE 16'h4000
// identifier kept for command and id-writing frames
`define LLS_ID_RSVD 6'h3C
// command slot pointers of the general-purpose writing frames
`define LLS_PTR_GP2 4'h0
`define LLS_PTR_GP4 4'h1
// number of command slot pointers held
`define LLS_SLOTS 10
// sleep-on-timeout value held through reset, before the configured bit is followed
`define LLS_SLEEP_RST 1'b0
`endif

// ===== hw/lls_pkg.sv
// ****************************************************************
// supervisor types
// ****************************************************************
package lls_pkg;

	// fail-safe sequencer states
	typedef enum logic [3:0] {
		ST_IDLE    = 4'b0000,
		ST_DECIDE  = 4'b0001,
		ST_REF_GO  = 4'b0010,
		ST_REF_RUN = 4'b0011,
		ST_ZERO    = 4'b0100,
		ST_BACK_GO = 4'b0101,
		ST_BACK_RN = 4'b0110,
		ST_SEC_GO  = 4'b0111,
		ST_SEC_RUN = 4'b1000,
		ST_FINISH  = 4'b1001,
		ST_STOPPED = 4'b1010,
		ST_SLEEP   = 4'b1011
	} lls_state_e;

	// one motion request towards the motion generator
	typedef struct packed {
		logic        start;
		logic        absolute;
		logic        negative;
		logic        otp_params;
		logic [15:0] target;
		logic [15:0] steps;
	} lls_move_s;

	// configuration bits held outside (otp or ram copy)
	typedef struct packed {
		logic        sleep_on_timeout;
		logic        fail_safe;
		logic        shaft;
		logic [10:0] secure_position;
	} lls_cfg_s;

	// one dynamic identifier write from the frame decoder
	typedef struct packed {
		logic       valid;
		logic [3:0] ptr;
		logic [5:0] id;
	} lls_dyn_wr_s;

endpackage

// ===== hw/lls_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
`include "lls_map.svh"
module lls_supervisor #(
	parameter int LOST_FRAMES = `LLS_LOST_FRAMES,
	parameter int SLOTS       = `LLS_SLOTS
) (
	input  wire logic                clk_in,
	input  wire logic                rst_in,
	input  wire logic                frame_slot_in,
	input  wire logic                frame_valid_in,
	input  wire lls_pkg::lls_dyn_wr_s dyn_wr_in,
	input  wire logic [5:0]          rx_id_in,
	input  wire lls_pkg::lls_cfg_s   cfg_in,
	input  wire logic                referenced_in,
	input  wire logic                addr_pin_two_float_in,
	input  wire logic                standby_in,
	input  wire logic                move_done_in,
	input  wire logic                stall_in,
	output var  logic [3:0]          command_slot_pointer_out,
	output var  logic                command_slot_hit_out,
	output var  logic                general_purpose_two_out,
	output var  logic                general_purpose_four_out,
	output var  lls_pkg::lls_move_s  move_out,
	output var  logic                dir_physical_out,
	output var  logic                clear_actual_position_out,
	output var  logic                link_lost_out,
	output var  logic                busy_out,
	output var  logic                stopped_out,
	output var  logic                sleep_out
);
	// ************************************************************
	// helpers
	// ************************************************************

	// 11 bit secure position, two full steps per unit, to full steps
	function automatic logic [15:0] sec_to_fs(input logic [10:0] s);
		sec_to_fs = {{4{s[10]}}, s, 1'b0};
	endfunction

	// secure positioning is wanted unless the position is 0x400
	function automatic logic sec_wanted(input logic [10:0] s);
		sec_wanted = (s != `LLS_SEC_NONE);
	endfunction

	// ************************************************************
	// declarations
	// ************************************************************
	lls_pkg::lls_state_e state;
	lls_pkg::lls_state_e next_state;
	logic [5:0]         slot_id  [SLOTS];
	logic [SLOTS-1:0]   slot_ok;
	logic               lost_event;
	logic               frame_seen;
	logic               sleep_en;
	logic               pin_two_q;
	logic               pin_two_rise;
	logic               cause_pin_two;
	logic               startup_loss;
	logic               sleep_ok;
	logic               trigger;
	logic               wr_ok;
	logic               look_hit;
	logic [3:0]         look_ptr;

	// ************************************************************
	// link watch
	// ************************************************************
	lls_frame_watch #(
		.LOST_FRAMES (LOST_FRAMES)
	) u_watch (
		.clk_in         (clk_in),
		.rst_in         (rst_in),
		.frame_slot_in  (frame_slot_in),
		.frame_valid_in (frame_valid_in),
		.link_lost_out  (link_lost_out),
		.lost_event_out (lost_event),
		.frame_seen_out (frame_seen)
	);

	// ************************************************************
	// dynamic identifier table
	// ************************************************************

	// pointers beyond the table are dropped; the master keeps
	// physical-select ids within eight motors
	assign wr_ok = dyn_wr_in.valid &&
		(dyn_wr_in.ptr < 4'(SLOTS)) &&
		(dyn_wr_in.id != `LLS_ID_RSVD);

	// slot index equals its command slot pointer
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			slot_ok <= '0;
		end else if (wr_ok) begin
			slot_ok[dyn_wr_in.ptr] <= 1'b1;
		end
	end

	// identifiers themselves need no reset: gated by slot_ok
	always_ff @(posedge clk_in) begin
		if (wr_ok) begin
			slot_id[dyn_wr_in.ptr] <= dyn_wr_in.id;
		end
	end

	// lowest matching slot wins if the master doubles an id
	always_comb begin
		look_hit = 1'b0;
		look_ptr = 4'h0;
		for (int i = SLOTS - 1; i >= 0; i--) begin
			if (slot_ok[i] && slot_id[i] == rx_id_in &&
				rx_id_in != `LLS_ID_RSVD) begin
				look_hit = 1'b1;
				look_ptr = 4'(i);
			end
		end
	end

	// registered lookup result and general-purpose frame flags
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			command_slot_pointer_out <= 4'h0;
			command_slot_hit_out     <= 1'b0;
			general_purpose_two_out  <= 1'b0;
			general_purpose_four_out <= 1'b0;
		end else begin
			command_slot_pointer_out <= look_ptr;
			command_slot_hit_out     <= look_hit;
			general_purpose_two_out  <= look_hit &&
				look_ptr == `LLS_PTR_GP2;
			general_purpose_four_out <= look_hit &&
				look_ptr == `LLS_PTR_GP4;
		end
	end

	// ************************************************************
	// triggers and configuration
	// ************************************************************

	// held disabled in reset, then follows the configured bit
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			sleep_en <= `LLS_SLEEP_RST;
		end else begin
			sleep_en <= cfg_in.sleep_on_timeout;
		end
	end

	// edge of the floating address pin starts handling once
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pin_two_q <= 1'b0;
		end else begin
			pin_two_q <= addr_pin_two_float_in;
		end
	end

	assign pin_two_rise = addr_pin_two_float_in && !pin_two_q;
	assign trigger      = lost_event || pin_two_rise;

	// remember cause and whether the loss came before any frame
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cause_pin_two <= 1'b0;
			startup_loss  <= 1'b0;
		end else if (state == lls_pkg::ST_IDLE && trigger) begin
			cause_pin_two <= !lost_event;
			startup_loss  <= !frame_seen;
		end
	end

	// no sleep while the pin floats but frames still arrive
	assign sleep_ok = (sleep_en || standby_in) &&
		!(cause_pin_two && !link_lost_out);

	// ************************************************************
	// fail-safe sequencer
	// ************************************************************
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state <= lls_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_comb begin
		next_state = state;
		case (state)
			lls_pkg::ST_IDLE: begin
				if (trigger) begin
					next_state = lls_pkg::ST_DECIDE;
				end
			end
			lls_pkg::ST_DECIDE: begin
				if (startup_loss) begin
					if (cfg_in.fail_safe && !referenced_in) begin
						next_state = lls_pkg::ST_REF_GO;
					end else if (sec_wanted(cfg_in.secure_position)) begin
						next_state = lls_pkg::ST_SEC_GO;
					end else begin
						next_state = lls_pkg::ST_FINISH;
					end
				end else if (referenced_in) begin
					if (sec_wanted(cfg_in.secure_position)) begin
						next_state = lls_pkg::ST_SEC_GO;
					end else begin
						next_state = lls_pkg::ST_FINISH;
					end
				end else if (cfg_in.fail_safe) begin
					next_state = lls_pkg::ST_REF_GO;
				end else begin
					next_state = lls_pkg::ST_FINISH;
				end
			end
			lls_pkg::ST_REF_GO: begin
				next_state = lls_pkg::ST_REF_RUN;
			end
			lls_pkg::ST_REF_RUN: begin
				// a run that ends without stall is taken as the end
				if (stall_in || move_done_in) begin
					next_state = lls_pkg::ST_ZERO;
				end
			end
			lls_pkg::ST_ZERO: begin
				next_state = lls_pkg::ST_BACK_GO;
			end
			lls_pkg::ST_BACK_GO: begin
				next_state = lls_pkg::ST_BACK_RN;
			end
			lls_pkg::ST_BACK_RN: begin
				if (move_done_in) begin
					if (sec_wanted(cfg_in.secure_position)) begin
						next_state = lls_pkg::ST_SEC_GO;
					end else begin
						next_state = lls_pkg::ST_FINISH;
					end
				end
			end
			lls_pkg::ST_SEC_GO: begin
				next_state = lls_pkg::ST_SEC_RUN;
			end
			lls_pkg::ST_SEC_RUN: begin
				if (move_done_in) begin
					next_state = lls_pkg::ST_FINISH;
				end
			end
			lls_pkg::ST_FINISH: begin
				if (sleep_ok) begin
					next_state = lls_pkg::ST_SLEEP;
				end else begin
					next_state = lls_pkg::ST_STOPPED;
				end
			end
			lls_pkg::ST_STOPPED, lls_pkg::ST_SLEEP: begin
				// link back and address known again: resume
				if (frame_valid_in && !addr_pin_two_float_in) begin
					next_state = lls_pkg::ST_IDLE;
				end
			end
			default: begin
				next_state = lls_pkg::ST_IDLE;
			end
		endcase
	end

	// ************************************************************
	// motion requests
	// ************************************************************

	// start is a one-cycle pulse; other fields stand until next
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			move_out <= '0;
		end else begin
			move_out.start <= 1'b0;
			case (state)
				lls_pkg::ST_REF_GO: begin
					move_out.start      <= 1'b1;
					move_out.absolute   <= 1'b0;
					move_out.negative   <= 1'b1;
					move_out.otp_params <= 1'b1;
					move_out.steps      <= `LLS_HALF_RANGE;
				end
				lls_pkg::ST_BACK_GO: begin
					move_out.start      <= 1'b1;
					move_out.absolute   <= 1'b0;
					move_out.negative   <= 1'b0;
					move_out.steps      <= `LLS_BACKOFF_FS;
				end
				lls_pkg::ST_SEC_GO: begin
					// ram copy is read live, so master updates count;
					// direction and otp use are dropped; steps and the
					// dir_physical_out level stay from the earlier move
					move_out.start      <= 1'b1;
					move_out.absolute   <= 1'b1;
					move_out.negative   <= 1'b0;
					move_out.otp_params <= 1'b0;
					move_out.target   <=
						sec_to_fs(cfg_in.secure_position);
				end
				default: begin
					move_out.start <= 1'b0;
				end
			endcase
		end
	end

	// physical direction of a relative move follows the shaft bit
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			dir_physical_out <= 1'b0;
		end else if (state == lls_pkg::ST_REF_GO) begin
			dir_physical_out <= !cfg_in.shaft;
		end else if (state == lls_pkg::ST_BACK_GO) begin
			dir_physical_out <= cfg_in.shaft;
		end
	end

	// zeroing pulse once the end stop is reached
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			clear_actual_position_out <= 1'b0;
		end else begin
			clear_actual_position_out <=
				(state == lls_pkg::ST_ZERO);
		end
	end

	// ************************************************************
	// status levels
	// ************************************************************
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			busy_out    <= 1'b0;
			stopped_out <= 1'b0;
			sleep_out   <= 1'b0;
		end else begin
			busy_out    <= next_state != lls_pkg::ST_IDLE &&
				next_state != lls_pkg::ST_STOPPED &&
				next_state != lls_pkg::ST_SLEEP;
			stopped_out <= next_state == lls_pkg::ST_STOPPED;
			sleep_out   <= next_state == lls_pkg::ST_SLEEP;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	sequence s_zeroed;
		state == lls_pkg::ST_ZERO ##1 clear_actual_position_out;
	endsequence

	sequence s_backoff;
		##1 move_out.start && !move_out.absolute &&
			!move_out.negative && move_out.steps == 16'h000A;
	endsequence

	a_back_off_ten : assert property (@(posedge clk_in)
		disable iff (rst_in) s_zeroed |-> s_backoff)
		else $error("back-off of ten full steps missing");

	a_zero_on_stall : assert property (@(posedge clk_in)
		disable iff (rst_in)
		state == lls_pkg::ST_REF_RUN && stall_in
		|=> ##1 clear_actual_position_out)
		else $error("actual position not cleared at end stop");

	a_no_ref_fs0 : assert property (@(posedge clk_in)
		disable iff (rst_in)
		state == lls_pkg::ST_DECIDE && !cfg_in.fail_safe
		|=> state != lls_pkg::ST_REF_GO)
		else $error("referencing run with fail-safe off");

	a_secure_target : assert property (@(posedge clk_in)
		disable iff (rst_in)
		state == lls_pkg::ST_SEC_GO |=> move_out.start &&
		move_out.absolute && move_out.target ==
		sec_to_fs($past(cfg_in.secure_position)))
		else $error("secure position not loaded as target");

	a_skip_secure : assert property (@(posedge clk_in)
		disable iff (rst_in)
		state == lls_pkg::ST_SEC_GO |->
		$past(cfg_in.secure_position) != 11'h400)
		else $error("secure positioning to 0x400");

	a_sleep_gate : assert property (@(posedge clk_in)
		disable iff (rst_in)
		$rose(sleep_out) |-> $past(sleep_en || standby_in))
		else $error("sleep entered without permission");

	a_finish_end : assert property (@(posedge clk_in)
		disable iff (rst_in)
		state == lls_pkg::ST_FINISH |=> stopped_out || sleep_out)
		else $error("handling did not end stopped or asleep");

	a_reserved_id : assert property (@(posedge clk_in)
		disable iff (rst_in)
		command_slot_hit_out |-> $past(rx_id_in) != 6'h3C &&
		command_slot_pointer_out < 4'(SLOTS))
		else $error("reserved identifier resolved to a slot");

	a_gp2_flag : assert property (@(posedge clk_in)
		disable iff (rst_in) general_purpose_two_out |->
		command_slot_hit_out && command_slot_pointer_out == 4'h0)
		else $error("general purpose flag on wrong pointer");

	a_link_lost_go : assert property (@(posedge clk_in)
		disable iff (rst_in)
		state == lls_pkg::ST_IDLE && lost_event
		|=> state == lls_pkg::ST_DECIDE ##1 busy_out)
		else $error("link loss did not start handling");

endmodule
`default_nettype wire

// ===== sim/lin_lost_failsafe_supervisor_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// supervisor bench
// ****************
module lin_lost_failsafe_supervisor_tb;
	logic                clk_in = 1'b0;
	logic                rst_in = 1'b1;
	logic                slot, fvalid, m_busy, busy;
	logic                m_start = 1'b0;
	logic                m_tail = 1'b0;
	logic                referenced = 1'b0;
	logic                pin = 1'b0;
	logic                stby = 1'b0;
	logic                done = 1'b0;
	logic                stall = 1'b0;
	logic [15:0]         m_miss = 16'h0000;
	logic [5:0]          rx_id = 6'h00;
	logic [5:0]          id0;
	logic [10:0]         sp;
	logic                sh;
	lls_pkg::lls_dyn_wr_s dyn = '0;
	lls_pkg::lls_cfg_s   cfg = '0;
	logic [3:0]          ptr;
	logic                hit, gp2, gp4, dir, clr, lost, stp, slp;
	lls_pkg::lls_move_s  mv;
	int                  fail_count = 0;
	int                  total_checks = 0;
	int                  cycles = 0;
	int                  clrs, e, seed;

	// short loss count keeps the run brief
	lls_supervisor #(.LOST_FRAMES(8)) dut (
		.clk_in(clk_in), .rst_in(rst_in), .frame_slot_in(slot),
		.frame_valid_in(fvalid), .dyn_wr_in(dyn), .rx_id_in(rx_id),
		.cfg_in(cfg), .referenced_in(referenced),
		.addr_pin_two_float_in(pin), .standby_in(stby),
		.move_done_in(done), .stall_in(stall),
		.command_slot_pointer_out(ptr), .command_slot_hit_out(hit),
		.general_purpose_two_out(gp2), .general_purpose_four_out(gp4),
		.move_out(mv), .dir_physical_out(dir),
		.clear_actual_position_out(clr), .link_lost_out(lost),
		.busy_out(busy), .stopped_out(stp), .sleep_out(slp));

	lls_lin_master master (
		.clk_in(clk_in), .rst_in(rst_in), .start_in(m_start),
		.miss_in(m_miss), .tail_in(m_tail), .frame_slot_out(slot),
		.frame_valid_out(fvalid), .busy_out(m_busy));

	// clock and hang guard
	always #12.5 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		cycles++;
		if (cycles > 6000) begin
			fail_count++;
			conclude();
		end
	end

	task chk(input string n, input logic [31:0] x, input logic [31:0] g);
		total_checks++;
		if (g !== x) begin
			$display("Error %s expected %h seen %h", n, x, g);
			fail_count++;
		end
	endtask

	task conclude;
		if (fail_count == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// target is in full steps: one secure unit is two full steps
	function logic [15:0] sec_tgt(input logic [10:0] s);
		return 16'($signed(s) * 2);
	endfunction

	task lin(input logic [15:0] n, input logic t, input bit w);
		@(posedge clk_in);
		m_start <= 1'b1;
		m_miss <= n;
		m_tail <= t;
		@(posedge clk_in);
		m_start <= 1'b0;
		if (w) begin
			@(negedge clk_in);
			for (int i = 0; i < 80 && m_busy; i++) @(negedge clk_in);
		end
	endtask

	// wait for a move start (1) or a final state (2), bounded
	task ev(output int r);
		r = 0;
		for (int i = 0; i < 60 && r == 0; i++) begin
			@(negedge clk_in);
			if (clr === 1'b1) clrs++;
			if (mv.start === 1'b1) r = 1;
			else if ((stp | slp) === 1'b1) r = 2;
		end
	endtask

	task pulse(input bit s);
		@(posedge clk_in);
		if (s) stall <= 1'b1;
		else done <= 1'b1;
		@(posedge clk_in);
		stall <= 1'b0;
		done <= 1'b0;
	endtask

	task wr(input logic [3:0] p, input logic [5:0] id);
		@(posedge clk_in);
		dyn <= {1'b1, p, id};
		@(posedge clk_in);
		dyn <= '0;
	endtask

	task lookup(input logic [5:0] id, input logic h, input logic [3:0] p);
		@(posedge clk_in);
		rx_id <= id;
		repeat (2) @(negedge clk_in);
		chk("slot hit", h, hit);
		if (h) chk("slot pointer", p, ptr);
		chk("general purpose", {h && p == 0, h && p == 1}, {gp2, gp4});
	endtask

	// one loss (or pin-two float) episode, then recovery by a frame
	task run(input logic [13:0] c, input logic r, input logic sb,
			input bit p, input bit mvx, input logic se);
		@(posedge clk_in);
		cfg <= c;
		referenced <= r;
		stby <= sb;
		repeat (3) @(posedge clk_in);
		if (p) pin <= 1'b1;
		else lin(16'h0008, 1'b0, 1'b0);
		ev(e);
		if (mvx) begin
			chk("secure move", {1'b1, 1'b1, sec_tgt(c[10:0])},
				{mv.start, mv.absolute, mv.target});
			pulse(1'b0);
			ev(e);
		end
		chk("final state", {2'd2, se, !se}, {2'(e), slp, stp});
		@(posedge clk_in);
		pin <= 1'b0;
		lin(16'h0000, 1'b1, 1'b1);
		repeat (2) @(negedge clk_in);
		chk("recovered", 3'b000, {stp, slp, lost});
	endtask

	// ****************
	// main sequence
	// ****************
	initial begin
		seed = $urandom(45);
		sp = 11'($urandom);
		if (sp == 11'h400) sp = 11'h401;
		sh = 1'($urandom);
		id0 = 6'(1 + $urandom % 29);
		repeat (5) @(posedge clk_in);
		rst_in <= 1'b0;
		@(negedge clk_in);
		chk("reset", 6'h00, {mv.start, stp, slp, lost, hit, busy});
		// startup loss, unreferenced, fail-safe on: referencing run
		@(posedge clk_in);
		cfg <= {1'b0, 1'b1, sh, sp};
		repeat (3) @(posedge clk_in);
		lin(16'h0008, 1'b0, 1'b0);
		clrs = 0;
		ev(e);
		chk("ref run", {5'b10111, 16'h4000, !sh, 1'b1}, {mv.start,
			mv.absolute, mv.negative, mv.otp_params, lost, mv.steps, dir,
			busy});
		pulse(1'b1);
		ev(e);
		chk("back-off", {2'b10, 16'h000A, sh, 4'h1},
			{mv.start, mv.negative, mv.steps, dir, 4'(clrs)});
		pulse(1'b0);
		ev(e);
		chk("secure", {2'b11, sec_tgt(sp)},
			{mv.start, mv.absolute, mv.target});
		pulse(1'b0);
		ev(e);
		chk("stopped", 4'b1010, {2'(e), stp, slp});
		// second reset, startup loss with fail-safe off
		@(posedge clk_in);
		rst_in <= 1'b1;
		repeat (5) @(posedge clk_in);
		rst_in <= 1'b0;
		run({1'b0, 1'b0, sh, sp}, 1'b0, 1'b0, 0, 1, 1'b0);
		// identifier table
		wr(4'h0, id0);
		wr(4'h1, id0 + 6'd30);
		wr(4'h2, 6'h3C);
		wr(4'hA, 6'h3D);
		lookup(id0, 1'b1, 4'h0);
		lookup(id0 + 6'd30, 1'b1, 4'h1);
		lookup(6'h3C, 1'b0, 4'h0);
		lookup(6'h3D, 1'b0, 4'h0);
		// seven misses then a frame never trips the flag
		repeat (2) lin(16'h0007, 1'b1, 1'b1);
		chk("no loss", 1'b0, lost);
		// losses and one pin-two float in operation
		run({1'b1, 1'b0, sh, sp}, 1'b1, 1'b0, 0, 1, 1'b1);
		run({1'b0, 1'b0, sh, sp}, 1'b0, 1'b0, 0, 0, 1'b0);
		run({1'b0, 1'b0, sh, sp}, 1'b0, 1'b1, 0, 0, 1'b1);
		run({1'b0, 1'b1, sh, 11'h400}, 1'b1, 1'b0, 0, 0, 1'b0);
		run({1'b1, 1'b0, sh, sp}, 1'b1, 1'b0, 1, 1, 1'b0);
		// in operation, unreferenced, no secure position: run ends on
		// done and no move follows the back-off
		@(posedge clk_in);
		cfg <= {1'b0, 1'b1, sh, 11'h400};
		referenced <= 1'b0;
		repeat (3) @(posedge clk_in);
		lin(16'h0008, 1'b0, 1'b0);
		ev(e);
		chk("ref run op", {2'b11, 16'h4000}, {mv.start, mv.negative,
			mv.steps});
		pulse(1'b0);
		ev(e);
		chk("back-off op", {2'b10, 16'h000A}, {mv.start, mv.negative,
			mv.steps});
		pulse(1'b0);
		ev(e);
		chk("no secure move", 4'b1010, {2'(e), stp, slp});
		conclude();
	end
endmodule
`default_nettype wire

// ===== sim/lls_lin_master.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// lin master model
// ****************
module lls_lin_master (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        start_in,
	input  wire logic [15:0] miss_in,
	input  wire logic        tail_in,
	output var  logic        frame_slot_out,
	output var  logic        frame_valid_out,
	output var  logic        busy_out
);
	logic [15:0] left;
	logic        tail;
	logic        phase;

	// silent slots every other cycle, then an optional valid frame
	// spacing of two cycles keeps slot pulses apart like real frames
	always_ff @(posedge clk_in) begin
		frame_slot_out  <= 1'b0;
		frame_valid_out <= 1'b0;
		phase           <= ~phase;
		if (rst_in) begin
			busy_out <= 1'b0;
			phase    <= 1'b0;
		end else if (!busy_out) begin
			busy_out <= start_in;
			left     <= miss_in;
			tail     <= tail_in;
		end else if (phase) begin
			if (left != 16'h0000) begin
				frame_slot_out <= 1'b1;
				left           <= left - 16'h0001;
			end else if (tail) begin
				frame_slot_out  <= 1'b1;
				frame_valid_out <= 1'b1;
				tail            <= 1'b0;
			end else begin
				busy_out <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire
